// ===== logic/sla_pkg.sv
package sla_pkg;

  // clock and timing
  localparam longint CLK_PERIOD_NS = 64'd10;
  localparam longint BIAS_HOLD_MS = 64'd2500; // bias hold-up after release
  localparam longint BIAS_HOLD_CYC =
    (BIAS_HOLD_MS * 64'd1000000) / CLK_PERIOD_NS;
  localparam longint SLOW_BLINK_MS = 64'd250; // half period, slow blink
  localparam longint SLOW_BLINK_CYC =
    (SLOW_BLINK_MS * 64'd1000000) / CLK_PERIOD_NS;
  localparam longint FAST_BLINK_MS = 64'd50; // half period, rapid blink
  localparam longint FAST_BLINK_CYC =
    (FAST_BLINK_MS * 64'd1000000) / CLK_PERIOD_NS;

  // register addresses, 16-bit register numbers
  localparam logic [15:0] ADDR_FAULT_STATUS = 16'h9cc1;
  localparam logic [15:0] ADDR_WARN_STATUS = 16'h9cc3;
  localparam logic [15:0] ADDR_A1_FAULT_MASK = 16'ha13f;
  localparam logic [15:0] ADDR_A1_WARN_MASK = 16'ha141;
  localparam logic [15:0] ADDR_A2_FAULT_MASK = 16'ha143;
  localparam logic [15:0] ADDR_A2_WARN_MASK = 16'ha145;
  localparam logic [15:0] ADDR_ALARM_POLARITY = 16'ha147;
  localparam logic [15:0] ADDR_A1_STATE_MASK = 16'ha148;
  localparam logic [15:0] ADDR_A2_STATE_MASK = 16'ha14a;
  localparam logic [15:0] ADDR_A1_MISC_MASK = 16'ha14c;
  localparam logic [15:0] ADDR_A2_MISC_MASK = 16'ha14d;
  localparam logic [15:0] ADDR_ISLAND_CFG = 16'ha73d;

  // reset values
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [1:0] POLARITY_RST = 2'h0;
  localparam logic [1:0] ISLAND_CFG_RST = 2'h0;

  // field positions
  localparam int ISLAND_CFG_EN_BIT = 0; // 1: pin selects mode
  localparam int ISLAND_CFG_DEF_BIT = 1; // mode when pin unused
  localparam int FAULT_HALT_BIT = 0; // halt fault in fault word

  // mask groups per alarm output
  localparam logic [1:0] GRP_FAULT = 2'h0;
  localparam logic [1:0] GRP_WARN = 2'h1;
  localparam logic [1:0] GRP_STATE = 2'h2;
  localparam logic [1:0] GRP_MISC = 2'h3;

  // decoded register selector
  typedef struct packed {
    logic hit; // any mapped register
    logic is_mask; // one of the alarm masks
    logic out_sel; // 0: first output, 1: second
    logic [1:0] grp; // mask group
    logic hi_half; // upper 16 bits of a 32-bit mask
  } sla_sel_t;

  // indicator drive
  typedef struct packed {
    logic green;
    logic yellow_stby;
    logic yellow_oper;
    logic red;
  } sla_led_t;

  // bias supply sequencing, one-bit steps except hold to off
  typedef enum logic [1:0] {
    BIAS_OFF = 2'b00,
    BIAS_RUN = 2'b01,
    BIAS_HOLD = 2'b11
  } sla_bias_t;

endpackage

// ===== logic/sla_top.sv
`timescale 1ns/1ns

// Function
// R1 - normal: green lit while bias runs
// R2 - normal: first yellow lit in standby
// R3 - normal: second yellow lit while converting
// R4 - normal: red lit while faulted
// R5 - bootloader: green blinks
// R6 - bootloader: first yellow on when host connected
// R7 - bootloader: second yellow rapid blink transferring
// R8 - bootloader: red on at bootloader error
// R9 - contactors closed only while halt asserted
// R10 - report halt fault when input deasserted
// R11 - bias holds about 2.5 s then off
// R12 - bias on while enable input asserted
// R13 - island input selects grid mode if configured
// R14 - two alarm outputs, selectable event mix
// R15 - alarm polarity set by configuration register
// R16 - four mask words per alarm output
// R17 - mask one enables source, zero blocks
// R18 - alarm is OR across all groups
// R19 - first output masks against shared status words
// R20 - second output uses same status words
// R21 - last bus unit needs termination jumper
// R22 - polarity applied after the OR
// R23 - bootloader flag chooses indicator meaning set
module sla_top
  import sla_pkg::*;
#(
  parameter int unsigned BIAS_HOLD_CYCLES = 32'(BIAS_HOLD_CYC),
  parameter int unsigned SLOW_BLINK_CYCLES = 32'(SLOW_BLINK_CYC),
  parameter int unsigned FAST_BLINK_CYCLES = 32'(FAST_BLINK_CYC)
)
(
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // register port, one 16-bit register per access
  input wire logic [15:0] I_REG_ADDR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [15:0] O_REG_RDATA,
  output logic O_REG_ACK,
  // discrete inputs
  input wire logic I_EMERGENCY_HALT_INPUT,
  input wire logic I_BIAS_ENABLE,
  input wire logic I_ISLAND_INPUT,
  // power converter status sources
  input wire logic [31:0] I_FAULT_SRC,
  input wire logic [31:0] I_WARN_SRC,
  input wire logic [4:0] I_POWER_CONVERTER_STATE,
  input wire logic [15:0] I_MISC_EVENTS,
  input wire logic I_STANDBY,
  input wire logic I_CONVERTING,
  input wire logic I_CONTACTOR_REQ,
  // bootloader status
  input wire logic I_BOOT_ACTIVE,
  input wire logic I_BOOT_HOST_LINK,
  input wire logic I_BOOT_XFER,
  input wire logic I_BOOT_ERROR,
  // outputs
  output logic O_BIAS_SUPPLY_EN,
  output logic O_CONTACTOR_CLOSE,
  output logic O_ISLAND_MODE,
  output logic O_LED_GREEN,
  output logic O_LED_YELLOW_STBY,
  output logic O_LED_YELLOW_OPER,
  output logic O_LED_RED,
  output logic O_ALARM_OUT_FIRST,
  output logic O_ALARM_OUT_SECOND
);

  // register address decode, shared by read and write paths
  function automatic sla_sel_t decode_addr(input logic [15:0] a);
    sla_sel_t s;
    s = '0;
    s.hit = 1'b1;
    s.is_mask = 1'b1;
    case (a)
      ADDR_A1_FAULT_MASK: s.hi_half = 1'b1;
      ADDR_A1_FAULT_MASK + 16'h0001: s.hi_half = 1'b0;
      ADDR_A1_WARN_MASK: {s.grp, s.hi_half} = {GRP_WARN, 1'b1};
      ADDR_A1_WARN_MASK + 16'h0001: s.grp = GRP_WARN;
      ADDR_A2_FAULT_MASK: {s.out_sel, s.hi_half} = 2'h3;
      ADDR_A2_FAULT_MASK + 16'h0001: s.out_sel = 1'b1;
      ADDR_A2_WARN_MASK:
        {s.out_sel, s.grp, s.hi_half} = {1'b1, GRP_WARN, 1'b1};
      ADDR_A2_WARN_MASK + 16'h0001: {s.out_sel, s.grp} = {1'b1, GRP_WARN};
      ADDR_A1_STATE_MASK: {s.grp, s.hi_half} = {GRP_STATE, 1'b1};
      ADDR_A1_STATE_MASK + 16'h0001: s.grp = GRP_STATE;
      ADDR_A2_STATE_MASK:
        {s.out_sel, s.grp, s.hi_half} = {1'b1, GRP_STATE, 1'b1};
      ADDR_A2_STATE_MASK + 16'h0001: {s.out_sel, s.grp} = {1'b1, GRP_STATE};
      ADDR_A1_MISC_MASK: s.grp = GRP_MISC;
      ADDR_A2_MISC_MASK: {s.out_sel, s.grp} = {1'b1, GRP_MISC};
      ADDR_FAULT_STATUS, ADDR_FAULT_STATUS + 16'h0001,
      ADDR_WARN_STATUS, ADDR_WARN_STATUS + 16'h0001,
      ADDR_ALARM_POLARITY, ADDR_ISLAND_CFG:
        s.is_mask = 1'b0;
      default:
      begin
        // unmapped: no hit, reads zero, writes dropped
        s.hit = 1'b0;
        s.is_mask = 1'b0;
      end
    endcase
    return s;
  endfunction

  // one-hot decode of the operating state for the state mask
  function automatic logic [31:0] state_onehot(input logic [4:0] st);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[st] = 1'b1;
    return v;
  endfunction

  sla_sel_t wr_sel; // decode of current write address
  sla_sel_t rd_sel; // decode of current read address
  logic [31:0] mask_q [2][4]; // alarm masks, [output][group]
  logic [1:0] polarity_q; // bit n inverts alarm output n
  logic [1:0] island_cfg_q; // enable and default mode
  logic [31:0] fault_word; // fault status as reported
  logic [31:0] warn_word; // warning status as reported
  logic [31:0] src_word [4]; // sources per mask group
  logic [1:0] alarm_raw; // OR of masked sources per output
  logic [1:0] alarm_q; // registered pin levels
  logic [15:0] rdata_d; // read mux result
  logic [15:0] rdata_q; // registered read data
  logic ack_q; // access answer strobe
  sla_bias_t bias_q; // bias sequencer state
  logic [31:0] hold_cnt_q; // hold-up countdown
  logic [31:0] slow_cnt_q; // slow blink divider
  logic [31:0] fast_cnt_q; // rapid blink divider
  logic slow_ph_q; // slow blink phase
  logic fast_ph_q; // rapid blink phase
  sla_led_t led_d; // indicator next value
  sla_led_t led_q; // indicator flops
  logic contactor_q; // contactor drive
  logic island_q; // selected grid mode
  logic halt_fault; // emergency halt missing

  assign wr_sel = decode_addr(I_REG_ADDR);
  assign rd_sel = wr_sel;

  // the halt fault is a plain level; it clears as soon as the pin returns
  assign halt_fault = ~I_EMERGENCY_HALT_INPUT; // R10

  // status words as seen by software and by both alarm outputs
  always_comb
  begin
    fault_word = I_FAULT_SRC;
    fault_word[FAULT_HALT_BIT] =
      I_FAULT_SRC[FAULT_HALT_BIT] | halt_fault; // R10
    warn_word = I_WARN_SRC;
  end

  // group sources, shared between both outputs
  always_comb
  begin
    src_word[GRP_FAULT] = fault_word; // R19 R20
    src_word[GRP_WARN] = warn_word; // R19 R20
    src_word[GRP_STATE] = state_onehot(I_POWER_CONVERTER_STATE);
    src_word[GRP_MISC] = {16'h0000, I_MISC_EVENTS};
  end

  // per-output mask registers and combine logic
  genvar go;
  genvar gg;
  generate
    for (go = 0; go < 2; go++)
    begin : g_out
      for (gg = 0; gg < 4; gg++)
      begin : g_grp
        // mask storage, written one 16-bit half per access
        always_ff @(posedge I_MCLK or negedge I_NRST)
        begin
          if (!I_NRST)
          begin
            mask_q[go][gg] <= MASK_RST;
          end
          else if (I_REG_WR && wr_sel.is_mask &&
                   wr_sel.out_sel == go[0] && wr_sel.grp == gg[1:0])
          begin
            // R16
            if (wr_sel.hi_half)
            begin
              mask_q[go][gg][31:16] <= I_REG_WDATA;
            end
            else
            begin
              mask_q[go][gg][15:0] <= I_REG_WDATA;
            end
          end
        end
      end
      // a one in a mask passes its source, any passing source alarms
      assign alarm_raw[go] =
        |(mask_q[go][GRP_FAULT] & src_word[GRP_FAULT]) | // R17 R18
        |(mask_q[go][GRP_WARN] & src_word[GRP_WARN]) |
        |(mask_q[go][GRP_STATE] & src_word[GRP_STATE]) |
        |(mask_q[go][GRP_MISC][15:0] & src_word[GRP_MISC][15:0]); // R14
    end
  endgenerate

  // polarity and island configuration registers
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      polarity_q <= POLARITY_RST;
      island_cfg_q <= ISLAND_CFG_RST;
    end
    else if (I_REG_WR)
    begin
      if (I_REG_ADDR == ADDR_ALARM_POLARITY)
      begin
        polarity_q <= I_REG_WDATA[1:0]; // R15
      end
      if (I_REG_ADDR == ADDR_ISLAND_CFG)
      begin
        island_cfg_q <= I_REG_WDATA[1:0]; // R13
      end
    end
  end

  // alarm pins: polarity applied after the OR, so one bit flips the sum
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      alarm_q <= 2'h0;
    end
    else
    begin
      alarm_q <= alarm_raw ^ polarity_q; // R22 R15
    end
  end

  assign O_ALARM_OUT_FIRST = alarm_q[0];
  assign O_ALARM_OUT_SECOND = alarm_q[1];

  // read mux; status words come live, not latched
  always_comb
  begin
    rdata_d = 16'h0000;
    if (rd_sel.is_mask)
    begin
      rdata_d = rd_sel.hi_half ? mask_q[rd_sel.out_sel][rd_sel.grp][31:16]
                               : mask_q[rd_sel.out_sel][rd_sel.grp][15:0];
    end
    else
    begin
      case (I_REG_ADDR)
        ADDR_FAULT_STATUS: rdata_d = fault_word[31:16];
        ADDR_FAULT_STATUS + 16'h0001: rdata_d = fault_word[15:0];
        ADDR_WARN_STATUS: rdata_d = warn_word[31:16];
        ADDR_WARN_STATUS + 16'h0001: rdata_d = warn_word[15:0];
        ADDR_ALARM_POLARITY: rdata_d = {14'h0000, polarity_q};
        ADDR_ISLAND_CFG: rdata_d = {14'h0000, island_cfg_q};
        default: rdata_d = 16'h0000; // unmapped reads zero
      endcase
    end
  end

  // register answer: one cycle after any read or write
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= I_REG_RD | I_REG_WR;
      if (I_REG_RD)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign O_REG_RDATA = rdata_q;
  assign O_REG_ACK = ack_q;

  // bias sequencer: run while enabled, hold up, then off
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      bias_q <= BIAS_OFF;
      hold_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      case (bias_q)
        BIAS_OFF:
        begin
          if (I_BIAS_ENABLE)
          begin
            bias_q <= BIAS_RUN; // R12
          end
        end
        BIAS_RUN:
        begin
          if (!I_BIAS_ENABLE)
          begin
            // housekeeping window starts here
            bias_q <= BIAS_HOLD; // R11
            hold_cnt_q <= BIAS_HOLD_CYCLES - 32'd1;
          end
        end
        BIAS_HOLD:
        begin
          if (I_BIAS_ENABLE)
          begin
            // re-assert during hold-up: keep running, no off glitch
            bias_q <= BIAS_RUN; // R12
          end
          else if (hold_cnt_q == 32'h0000_0000)
          begin
            bias_q <= BIAS_OFF; // R11
          end
          else
          begin
            hold_cnt_q <= hold_cnt_q - 32'd1;
          end
        end
        default:
        begin
          bias_q <= BIAS_OFF;
        end
      endcase
    end
  end

  // supply is on in run and in the whole hold-up window
  assign O_BIAS_SUPPLY_EN = (bias_q != BIAS_OFF); // R11 R12

  // contactors follow the request only with the halt input present
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      contactor_q <= 1'b0;
    end
    else
    begin
      contactor_q <= I_CONTACTOR_REQ & I_EMERGENCY_HALT_INPUT; // R9
    end
  end

  // the real hardware path is direct; gate combinationally as well
  assign O_CONTACTOR_CLOSE = contactor_q & I_EMERGENCY_HALT_INPUT; // R9

  // island mode: pin when enabled, else the configured default
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      island_q <= 1'b0;
    end
    else if (island_cfg_q[ISLAND_CFG_EN_BIT])
    begin
      island_q <= I_ISLAND_INPUT; // R13
    end
    else
    begin
      // unused pin may float, so it is ignored here
      island_q <= island_cfg_q[ISLAND_CFG_DEF_BIT]; // R13
    end
  end

  assign O_ISLAND_MODE = island_q;

  // blink dividers, free running so both rates stay in phase
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      slow_cnt_q <= 32'h0000_0000;
      slow_ph_q <= 1'b0;
    end
    else if (slow_cnt_q >= SLOW_BLINK_CYCLES - 32'd1)
    begin
      slow_cnt_q <= 32'h0000_0000;
      slow_ph_q <= ~slow_ph_q;
    end
    else
    begin
      slow_cnt_q <= slow_cnt_q + 32'd1;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      fast_cnt_q <= 32'h0000_0000;
      fast_ph_q <= 1'b0;
    end
    else if (fast_cnt_q >= FAST_BLINK_CYCLES - 32'd1)
    begin
      fast_cnt_q <= 32'h0000_0000;
      fast_ph_q <= ~fast_ph_q;
    end
    else
    begin
      fast_cnt_q <= fast_cnt_q + 32'd1;
    end
  end

  // indicator meaning set chosen by the bootloader flag
  always_comb
  begin
    if (I_BOOT_ACTIVE) // R23
    begin
      led_d.green = slow_ph_q; // R5
      led_d.yellow_stby = I_BOOT_HOST_LINK; // R6
      led_d.yellow_oper = I_BOOT_XFER & fast_ph_q; // R7
      led_d.red = I_BOOT_ERROR; // R8
    end
    else
    begin
      led_d.green = O_BIAS_SUPPLY_EN; // R1
      led_d.yellow_stby = I_STANDBY; // R2
      led_d.yellow_oper = I_CONVERTING; // R3
      led_d.red = |fault_word; // R4
    end
  end

  // indicator flops
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      led_q <= '0;
    end
    else
    begin
      led_q <= led_d;
    end
  end

  assign O_LED_GREEN = led_q.green;
  assign O_LED_YELLOW_STBY = led_q.yellow_stby;
  assign O_LED_YELLOW_OPER = led_q.yellow_oper;
  assign O_LED_RED = led_q.red;

endmodule

// ===== test/sla_site_ctrl.sv
`timescale 1ns/1ns

// site controller driving the isolated inputs
module sla_site_ctrl
(
  input wire logic i_clk,
  input wire logic i_want_halt,
  input wire logic i_want_bias,
  input wire logic i_want_island,
  output logic o_halt,
  output logic o_bias,
  output logic o_island
);
  logic halt_v; // wanted halt level at the last edge
  logic bias_v; // wanted bias level at the last edge
  logic isl_v; // wanted island level at the last edge

  // wishes taken on the edge, shown just after it; the bench moves its
  // wishes in that same step, so reading them late would race
  initial
  begin
    // power not allowed until commanded
    o_halt = 1'b0;
    o_bias = 1'b0;
    o_island = 1'b0;
    forever
    begin
      @(posedge i_clk);
      halt_v = i_want_halt;
      bias_v = i_want_bias;
      isl_v = i_want_island;
      #1;
      o_halt = halt_v;
      o_bias = bias_v;
      o_island = isl_v;
    end
  end
endmodule

// ===== test/sla_top_bench.sv
`timescale 1ns/1ns

module sla_top_bench
  import sla_pkg::*;
;
  localparam int HOLD = 20; // shortened hold-up
  localparam int SLOW = 4;
  localparam int FAST = 2;
  localparam logic [15:0] MTAB [8] = '{ADDR_A1_FAULT_MASK,
    ADDR_A1_WARN_MASK + 16'h1, ADDR_A2_FAULT_MASK, ADDR_A2_WARN_MASK + 16'h1,
    ADDR_A1_STATE_MASK, ADDR_A2_STATE_MASK + 16'h1, ADDR_A1_MISC_MASK,
    ADDR_A2_MISC_MASK};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] fsrc = 32'h1234_5670; // fault sources
  logic [31:0] wsrc = 32'h0000_00a5; // warning sources
  logic [4:0] pstate = 5'h0;
  logic [15:0] misc = 16'h0;
  logic stby = 1'b0;
  logic conv = 1'b0;
  logic creq = 1'b0;
  logic [3:0] boot = 4'h0; // active, link, transfer, error
  logic want_halt = 1'b0;
  logic want_bias = 1'b0;
  logic want_isl = 1'b0;
  logic halt, bias_in, isl, ack, bias, close, isl_mode;
  logic [15:0] rdata;
  logic [15:0] q;
  logic [1:0] alarm;
  sla_led_t led;
  int n_fail = 0;
  int cmp_count = 0;
  int g_tog, o_tog;

  sla_top #(
    .BIAS_HOLD_CYCLES(HOLD),
    .SLOW_BLINK_CYCLES(SLOW),
    .FAST_BLINK_CYCLES(FAST)
  ) dut_u (
    .I_MCLK(mclk), .I_NRST(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_REG_ACK(ack),
    .I_EMERGENCY_HALT_INPUT(halt), .I_BIAS_ENABLE(bias_in),
    .I_ISLAND_INPUT(isl), .I_FAULT_SRC(fsrc), .I_WARN_SRC(wsrc),
    .I_POWER_CONVERTER_STATE(pstate), .I_MISC_EVENTS(misc),
    .I_STANDBY(stby), .I_CONVERTING(conv), .I_CONTACTOR_REQ(creq),
    .I_BOOT_ACTIVE(boot[3]), .I_BOOT_HOST_LINK(boot[2]),
    .I_BOOT_XFER(boot[1]), .I_BOOT_ERROR(boot[0]),
    .O_BIAS_SUPPLY_EN(bias), .O_CONTACTOR_CLOSE(close),
    .O_ISLAND_MODE(isl_mode), .O_LED_GREEN(led.green),
    .O_LED_YELLOW_STBY(led.yellow_stby), .O_LED_YELLOW_OPER(led.yellow_oper),
    .O_LED_RED(led.red), .O_ALARM_OUT_FIRST(alarm[1]),
    .O_ALARM_OUT_SECOND(alarm[0])
  );

  sla_site_ctrl site_u (
    .i_clk(mclk), .i_want_halt(want_halt), .i_want_bias(want_bias),
    .i_want_island(want_isl), .o_halt(halt), .o_bias(bias_in),
    .o_island(isl)
  );

  // free-running system clock
  always #5 mclk = ~mclk;

  // verdict and end of run
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // n edges, then settle just past the last one
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one register access; strobe lasts one cycle, answer the next;
  // a spare edge after it so a following call never re-raises a strobe
  // in the step that lowered it, and the answer is seen to drop again
  task automatic reg_acc(input logic w, input logic [15:0] a,
    input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    step(1);
    wr = 1'b0;
    rd = 1'b0;
    check(ack, 1'b1);
    q = rdata;
    step(1);
    check(ack, 1'b0);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    reg_acc(1'b0, a, 16'h0);
    check(q, exp);
  endtask

  // alarm pins checked three edges after the previous access returns
  task automatic al(input logic [1:0] exp);
    step(3);
    check(alarm, exp);
  endtask

  initial
  begin
    #50000;
    n_fail++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    step(2);
    rd_chk(16'h0000, 16'h0);
    reg_acc(1'b1, ADDR_FAULT_STATUS, 16'h0000);
    rd_chk(ADDR_FAULT_STATUS, 16'h1234);
    rd_chk(ADDR_FAULT_STATUS + 16'h1, 16'h5671);
    rd_chk(ADDR_WARN_STATUS + 16'h1, 16'h00a5);
    for (int i = 0; i < 8; i++)
    begin
      rd_chk(MTAB[i], 16'h0);
      reg_acc(1'b1, MTAB[i], 16'ha500 | 16'(i));
      rd_chk(MTAB[i], 16'ha500 | 16'(i));
      reg_acc(1'b1, MTAB[i], 16'h0);
    end
    al(2'b00);
    reg_acc(1'b1, ADDR_A1_FAULT_MASK + 16'h1, 16'h0001);
    al(2'b10);
    want_halt = 1'b1;
    al(2'b00);
    creq = 1'b1;
    step(3);
    check(close, 1'b1);
    want_halt = 1'b0;
    step(2);
    check(close, 1'b0);
    want_halt = 1'b1;
    pstate = 5'h3;
    reg_acc(1'b1, ADDR_A1_STATE_MASK + 16'h1, 16'h0008);
    al(2'b10);
    pstate = 5'h4;
    reg_acc(1'b1, ADDR_A2_FAULT_MASK, 16'h0004);
    al(2'b01);
    reg_acc(1'b1, ADDR_A2_FAULT_MASK, 16'h0000);
    reg_acc(1'b1, ADDR_A2_WARN_MASK + 16'h1, 16'h0080);
    al(2'b01);
    misc = 16'h0002;
    reg_acc(1'b1, ADDR_A2_MISC_MASK, 16'h0002);
    reg_acc(1'b1, ADDR_A2_WARN_MASK + 16'h1, 16'h0000);
    al(2'b01);
    reg_acc(1'b1, ADDR_ALARM_POLARITY, 16'h0003);
    rd_chk(ADDR_ALARM_POLARITY, 16'h0003);
    al(2'b10);
    misc = 16'h0000;
    pstate = 5'h3;
    al(2'b01);
    reg_acc(1'b1, ADDR_ALARM_POLARITY, 16'h0000);
    al(2'b10);
    want_bias = 1'b1;
    stby = 1'b1;
    conv = 1'b1;
    step(4);
    check({bias, led}, 5'h1f);
    want_bias = 1'b0;
    step(12);
    check(bias, 1'b1);
    step(18);
    check(bias, 1'b0);
    reg_acc(1'b1, ADDR_ISLAND_CFG, 16'h0002);
    step(2);
    check(isl_mode, 1'b1);
    reg_acc(1'b1, ADDR_ISLAND_CFG, 16'h0001);
    step(2);
    check(isl_mode, 1'b0);
    want_isl = 1'b1;
    step(3);
    check(isl_mode, 1'b1);
    boot = 4'hf;
    step(2);
    check({led.yellow_stby, led.red}, 2'b11);
    g_tog = 0;
    o_tog = 0;
    repeat (40)
    begin
      q[1:0] = {led.green, led.yellow_oper};
      step(1);
      g_tog += int'(led.green !== q[1]);
      o_tog += int'(led.yellow_oper !== q[0]);
    end
    check(g_tog, 40 / SLOW);
    check(o_tog, 40 / FAST);
    boot = 4'h8;
    step(3);
    check({led.yellow_stby, led.yellow_oper, led.red}, 3'h0);
    close_out();
  end
endmodule

// ===== test/sla_top_checker.sv
`timescale 1ns/1ns

module sla_top_checker
  import sla_pkg::*;
#(
  parameter int unsigned BIAS_HOLD_CYCLES = 20,
  parameter int unsigned SLOW_BLINK_CYCLES = 4
)
(
  input wire logic I_MCLK,
  input wire logic I_NRST,
  input wire logic I_EMERGENCY_HALT_INPUT,
  input wire logic I_BIAS_ENABLE,
  input wire logic [31:0] I_FAULT_SRC,
  input wire logic I_STANDBY,
  input wire logic I_CONVERTING,
  input wire logic I_CONTACTOR_REQ,
  input wire logic I_BOOT_ACTIVE,
  input wire logic I_BOOT_HOST_LINK,
  input wire logic I_BOOT_ERROR,
  input wire logic O_BIAS_SUPPLY_EN,
  input wire logic O_CONTACTOR_CLOSE,
  input wire logic O_LED_GREEN,
  input wire logic O_LED_YELLOW_STBY,
  input wire logic O_LED_YELLOW_OPER,
  input wire logic O_LED_RED
);
  int low_q; // edges in a row with bias enable low
  logic was_on_q; // enable seen high since reset
  int same_q; // boot cycles with green unchanged

  // release span, saturating so a stuck supply still trips
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      low_q <= 0;
    else if (I_BIAS_ENABLE)
      low_q <= 0;
    else if (low_q < 1000)
      low_q <= low_q + 1;
  end

  // hold-up only owed once the supply was started
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      was_on_q <= 1'b0;
    else if (I_BIAS_ENABLE)
      was_on_q <= 1'b1;
  end

  // a frozen blink shows as a long stable run
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      same_q <= 0;
    else if (!I_BOOT_ACTIVE || !$stable(O_LED_GREEN))
      same_q <= 0;
    else if (same_q < 1000)
      same_q <= same_q + 1;
  end

  default clocking dc @(posedge I_MCLK);
  endclocking
  default disable iff (!I_NRST);

  // close request seen with the halt input present, input still there
  sequence close_s;
    (I_CONTACTOR_REQ && I_EMERGENCY_HALT_INPUT) ##1 I_EMERGENCY_HALT_INPUT;
  endsequence
  // normal meaning set held with the supply up
  sequence norm_on_s;
    (!I_BOOT_ACTIVE && O_BIAS_SUPPLY_EN)[*3];
  endsequence

  chk_bias_run: assert property (
    I_BIAS_ENABLE |=> O_BIAS_SUPPLY_EN)
    else $error("bias supply not running while enabled");
  chk_bias_keep: assert property (
    (was_on_q && low_q inside {[1:BIAS_HOLD_CYCLES]}) |-> O_BIAS_SUPPLY_EN)
    else $error("bias supply dropped inside hold-up");
  chk_bias_off: assert property (
    (low_q > BIAS_HOLD_CYCLES + 2) |-> !O_BIAS_SUPPLY_EN)
    else $error("bias supply still on after hold-up");
  chk_halt_open: assert property (
    !I_EMERGENCY_HALT_INPUT |-> !O_CONTACTOR_CLOSE)
    else $error("contactors closed without halt input");
  chk_halt_close: assert property (
    close_s |-> O_CONTACTOR_CLOSE)
    else $error("contactors not closed on request");
  chk_halt_fault: assert property (
    (!I_EMERGENCY_HALT_INPUT && !I_BOOT_ACTIVE) |=> O_LED_RED)
    else $error("halt fault not shown");
  chk_norm_red: assert property (
    (!I_BOOT_ACTIVE && |I_FAULT_SRC) |=> O_LED_RED)
    else $error("red off while faulted");
  chk_norm_yellow: assert property (
    !I_BOOT_ACTIVE |=> (O_LED_YELLOW_STBY == $past(I_STANDBY)
      && O_LED_YELLOW_OPER == $past(I_CONVERTING)))
    else $error("yellow indicators wrong in normal mode");
  chk_norm_green: assert property (
    norm_on_s |-> O_LED_GREEN)
    else $error("green off while supply runs");
  chk_boot_leds: assert property (
    I_BOOT_ACTIVE |=> (O_LED_YELLOW_STBY == $past(I_BOOT_HOST_LINK)
      && O_LED_RED == $past(I_BOOT_ERROR)))
    else $error("boot indicators wrong");
  chk_green_blink: assert property (
    same_q <= SLOW_BLINK_CYCLES + 2)
    else $error("green not blinking in boot mode");
endmodule

bind sla_top sla_top_checker #(
  .BIAS_HOLD_CYCLES(BIAS_HOLD_CYCLES),
  .SLOW_BLINK_CYCLES(SLOW_BLINK_CYCLES)
) chk_u (
  .I_MCLK, .I_NRST, .I_EMERGENCY_HALT_INPUT, .I_BIAS_ENABLE, .I_FAULT_SRC,
  .I_STANDBY, .I_CONVERTING, .I_CONTACTOR_REQ, .I_BOOT_ACTIVE,
  .I_BOOT_HOST_LINK, .I_BOOT_ERROR, .O_BIAS_SUPPLY_EN, .O_CONTACTOR_CLOSE,
  .O_LED_GREEN, .O_LED_YELLOW_STBY, .O_LED_YELLOW_OPER, .O_LED_RED
);
